// [rtl/capture_pkg.sv]
// Purpose: shared constants for the edge position capture block
// Assumes: object-dictionary style access, sub-index as register address
// Notes:   one clock, asynchronous active-low reset
package capture_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned POS_W  = 32;

  localparam logic [7:0] ADDR_MODE   = 8'h01;
  localparam logic [7:0] ADDR_FLAGS  = 8'h02;
  localparam logic [7:0] ADDR_VIS    = 8'h03;
  localparam logic [7:0] ADDR_REARM  = 8'h04;
  localparam logic [7:0] ADDR_POS_UP = 8'h05;
  localparam logic [7:0] ADDR_POS_DN = 8'h06;

  localparam int unsigned BIT_FALL    = 0;
  localparam int unsigned BIT_RISE    = 1;
  localparam int unsigned BIT_SUMMARY = 15;

  localparam logic [15:0] MODE_CONTINUOUS = 16'h0000;
  localparam logic [15:0] MODE_AUTOLOCK   = 16'h0001;

  localparam logic [15:0] MODE_RESET  = 16'h0001;
  localparam logic [7:0]  VIS_RESET   = 8'h03;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [1:0]  ARM_RESET   = 2'b11;
endpackage : capture_pkg

// [rtl/input_sync.sv]
// Purpose: three-stage synchroniser for the probe pin with edge detect
// Assumes: pin is asynchronous to clk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module input_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // accepted level only moves when the two late stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign rise = (s2_ff == s3_ff) && s3_ff && !level_ff;
  assign fall = (s2_ff == s3_ff) && !s3_ff && level_ff;
endmodule : input_sync

// [rtl/edge_latch.sv]
// Purpose: one edge direction: arm state, event flag, latched position
// Assumes: edge pulse is one cycle, synchronous to clk
// Notes:   instantiated once for rising, once for falling
`timescale 1ns/1ps
module edge_latch
  import capture_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             edge_hit,
  input  wire logic             autolock,
  input  wire logic             rearm,
  input  wire logic [POS_W-1:0] position,
  output logic                  flag,
  output logic [POS_W-1:0]      pos
);
  logic armed_ff;
  logic flag_ff;
  logic [POS_W-1:0] pos_ff;
  logic take;

  // continuous mode ignores the arm state entirely
  assign take = edge_hit && (armed_ff || !autolock);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_ff <= ARM_RESET[0];
    end else if (take && autolock) begin
      armed_ff <= 1'b0;
    end else if (rearm) begin
      armed_ff <= 1'b1;
    end
  end

  // set beats clear so an edge during a clear is not lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= FLAGS_RESET[0];
    end else if (take) begin
      flag_ff <= 1'b1;
    end else if (rearm) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_ff <= '0;
    end else if (take) begin
      pos_ff <= position;
    end
  end

  assign flag = flag_ff;
  assign pos  = pos_ff;
endmodule : edge_latch

// [rtl/edge_position_capture.sv]
// Purpose: latch actual position on probe edges, report via flags
// Assumes: simple synchronous register port addressed by sub-index
// Notes:   read data is registered, valid one cycle after rd_en
`timescale 1ns/1ps

// Functional notes
// - latch position on rising and falling edges
// - mode 0 continuous, mode 1 autolock
// - autolock ignores edges until re-enabled
// - rising and falling detection run independently
// - flags: bit0 falling, bit1 rising
// - status_summary output when visible flag set
// - mask bit0 falling, bit1 rising
// - control write clears flag, re-arms autolock
// - control bit0 falling, bit1 rising
// - positions held in unsigned 32-bit registers, copied bit for bit from signed actual_pos
module edge_position_capture
  import capture_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     probe_pin,
  input  wire logic signed [POS_W-1:0]  actual_pos,
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic                     wr_en,
  input  wire logic [DATA_W-1:0]        wr_data,
  input  wire logic                     rd_en,
  output logic [DATA_W-1:0]             rd_data,
  output logic                          rd_valid,
  output logic                          rd_error,
  output logic                          status_summary
);
  import capture_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]      mode_ff;
  logic [7:0]       vis_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic             rd_valid_ff;
  logic             rd_error_ff;
  logic             summary_ff;
  logic             rise_hit;
  logic             fall_hit;
  logic             autolock;
  logic             rearm_up;
  logic             rearm_dn;
  logic             flag_up;
  logic             flag_dn;
  logic [POS_W-1:0] pos_up;
  logic [POS_W-1:0] pos_dn;
  logic [7:0]       flags;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  input_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (probe_pin),
    .rise    (rise_hit),
    .fall    (fall_hit)
  );

  // only value 1 locks; other values behave as continuous
  assign autolock = (mode_ff == MODE_AUTOLOCK);

  // write-only control: pulses only, nothing stored
  assign rearm_dn = wr_en && hit(addr, ADDR_REARM) && wr_data[BIT_FALL];
  assign rearm_up = wr_en && hit(addr, ADDR_REARM) && wr_data[BIT_RISE];

  // two separate latches, so a bouncing pulse can fire both
  edge_latch u_up (
    .clk      (clk),
    .reset_n  (reset_n),
    .edge_hit (rise_hit),
    .autolock (autolock),
    .rearm    (rearm_up),
    .position (actual_pos),
    .flag     (flag_up),
    .pos      (pos_up)
  );

  edge_latch u_dn (
    .clk      (clk),
    .reset_n  (reset_n),
    .edge_hit (fall_hit),
    .autolock (autolock),
    .rearm    (rearm_dn),
    .position (actual_pos),
    .flag     (flag_dn),
    .pos      (pos_dn)
  );

  always_comb begin
    flags = 8'h00;
    flags[BIT_FALL] = flag_dn;
    flags[BIT_RISE] = flag_up;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= MODE_RESET;
    end else if (wr_en && hit(addr, ADDR_MODE)) begin
      mode_ff <= wr_data[15:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vis_ff <= VIS_RESET;
    end else if (wr_en && hit(addr, ADDR_VIS)) begin
      vis_ff <= wr_data[7:0];
    end
  end

  // summary lags the flags by one cycle; software polls it anyway
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      summary_ff <= 1'b0;
    end else begin
      summary_ff <= |(flags & vis_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
      rd_error_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en;
      rd_error_ff <= 1'b0;
      rd_data_ff  <= '0;
      if (rd_en) begin
        case (addr)
          ADDR_MODE:   rd_data_ff <= {16'h0000, mode_ff};
          ADDR_FLAGS:  rd_data_ff <= {24'h00_0000, flags};
          ADDR_VIS:    rd_data_ff <= {24'h00_0000, vis_ff};
          ADDR_POS_UP: rd_data_ff <= pos_up;
          ADDR_POS_DN: rd_data_ff <= pos_dn;
          // control is write-only; unmapped also flags an error
          default:     rd_error_ff <= 1'b1;
        endcase
      end
    end
  end

  assign rd_data        = rd_data_ff;
  assign rd_valid       = rd_valid_ff;
  assign rd_error       = rd_error_ff;
  assign status_summary = summary_ff;
endmodule : edge_position_capture

// [test/capture_monitor.sv]
// Purpose: port checker for the capture block
// Assumes: read answer one cycle after rd_en
// Notes:   bound to every instance
`timescale 1ns/1ps
module capture_monitor
  import capture_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              rd_valid,
  input wire logic              rd_error,
  input wire logic              status_summary
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic bad;
  // write-only and unmapped places must never read back
  assign bad = addr == ADDR_REARM || addr == 8'h00 || addr > ADDR_POS_DN;
  sequence s_req; rd_en; endsequence
  sequence s_ans; rd_valid; endsequence
  ////////
  a_read_answer: assert property (s_req |=> s_ans) else $error("no answer");
  a_stray_answer: assert property (!rd_en |=> !rd_valid) else $error("stray answer");
  a_rearm_unread: assert property (rd_en && bad |=> rd_error && rd_data == 32'h0000_0000)
    else $error("bad read");
  a_mapped_ok: assert property (rd_en && !bad |=> !rd_error) else $error("false error");
  a_flags_width: assert property (rd_en && addr == ADDR_FLAGS |=> rd_data[31:2] == 30'h0)
    else $error("flags wide");
  a_vis_width: assert property (rd_en && addr == ADDR_VIS |=> rd_data[31:8] == 24'h0)
    else $error("mask wide");
  a_mode_width: assert property (rd_en && addr == ADDR_MODE |=> rd_data[31:16] == 16'h0)
    else $error("mode wide");
  // summary only drops after a clear or a mask write
  a_summary_fall: assert property ($fell(status_summary) |-> $past(wr_en, 2) || $past(wr_en))
    else $error("summary dropped");
endmodule : capture_monitor

bind edge_position_capture capture_monitor i_capture_monitor (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
  .rd_error(rd_error), .status_summary(status_summary));

// [test/fieldbus_ctrl.sv]
// Purpose: controller model issuing register reads and writes
// Assumes: one access per task call
// Notes:   released lines show inverted values
`timescale 1ns/1ps
module fieldbus_ctrl
  import capture_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              status_summary,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic [ADDR_W-1:0]      addr,
  output logic                   wr_en,
  output logic [DATA_W-1:0]      wr_data,
  output logic                   rd_en
);
  initial begin
    addr = 8'h00;
    wr_en = 1'b0;
    wr_data = 32'h0000_0000;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~v;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    v = rd_data;
  endtask : rd
  // flags are fetched once the summary bit shows an event, or after 50 cycles without one
  task automatic poll(output logic [DATA_W-1:0] v);
    int n;
    n = 0;
    while (status_summary !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd(ADDR_FLAGS, v);
  endtask : poll
endmodule : fieldbus_ctrl

// [test/edge_position_capture_test.sv]
// Purpose: register level test of the capture block
// Assumes: probe held 8 cycles per level
// Notes:   reset defaults autolock, mask 3
`timescale 1ns/1ps
module edge_position_capture_test;
  import capture_pkg::*;
  logic clk, reset_n, probe_pin, wr_en, rd_en, rd_valid, rd_error, status_summary;
  logic signed [POS_W-1:0]  actual_pos;
  logic [ADDR_W-1:0]        addr;
  logic [DATA_W-1:0]        wr_data, rd_data, d;
  int                       failures, samples_checked;
  edge_position_capture i_edge_position_capture (.clk(clk), .reset_n(reset_n),
    .probe_pin(probe_pin), .actual_pos(actual_pos), .addr(addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error), .status_summary(status_summary));
  fieldbus_ctrl i_fieldbus_ctrl (.clk(clk), .status_summary(status_summary), .rd_data(rd_data),
    .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_fieldbus_ctrl.rd(a, d);
    chk(d, e);
  endtask : rc
  task automatic sc(input logic e);
    repeat (3) @(posedge clk);
    chk({31'b0, status_summary}, {31'b0, e});
  endtask : sc
  // 8 cycles covers the synchroniser delay plus flag and summary lag
  task automatic pin(input logic v, input logic [POS_W-1:0] p);
    @(posedge clk);
    actual_pos <= p;
    probe_pin <= v;
    repeat (8) @(posedge clk);
  endtask : pin
  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  ////////
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    probe_pin = 1'b0;
    actual_pos = 32'h0000_0000;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rc(ADDR_MODE, 32'h0000_0001);
    rc(ADDR_VIS, 32'h0000_0003);
    rc(ADDR_FLAGS, 32'h0000_0000);
    rc(ADDR_REARM, 32'h0000_0000);
    pin(1'b1, 32'h0000_0064);
    i_fieldbus_ctrl.poll(d);
    chk(d, 32'h0000_0002);
    pin(1'b0, 32'hFFFF_FFFB);
    rc(ADDR_FLAGS, 32'h0000_0003);
    pin(1'b1, 32'h0000_00C8);
    rc(ADDR_POS_UP, 32'h0000_0064);
    i_fieldbus_ctrl.wr(ADDR_REARM, 32'h0000_0002);
    rc(ADDR_FLAGS, 32'h0000_0001);
    pin(1'b0, 32'h0000_0001);
    pin(1'b1, 32'h0000_012C);
    rc(ADDR_POS_UP, 32'h0000_012C);
    rc(ADDR_POS_DN, 32'hFFFF_FFFB);
    i_fieldbus_ctrl.wr(ADDR_VIS, 32'h0000_0000);
    sc(1'b0);
    i_fieldbus_ctrl.wr(ADDR_VIS, 32'h0000_0001);
    sc(1'b1);
    i_fieldbus_ctrl.wr(ADDR_REARM, 32'h0000_0001);
    sc(1'b0);
    i_fieldbus_ctrl.wr(ADDR_VIS, 32'h0000_0002);
    sc(1'b1);
    i_fieldbus_ctrl.wr(ADDR_MODE, 32'h0000_0000);
    rc(ADDR_MODE, 32'h0000_0000);
    i_fieldbus_ctrl.wr(ADDR_REARM, 32'h0000_0003);
    pin(1'b0, 32'h0000_0001);
    pin(1'b1, 32'h0000_0002);
    pin(1'b0, 32'h0000_0003);
    rc(ADDR_POS_DN, 32'h0000_0003);
    i_fieldbus_ctrl.wr(ADDR_FLAGS, 32'h0000_0000);
    rc(ADDR_FLAGS, 32'h0000_0003);
    results();
  end
endmodule : edge_position_capture_test
